//--- shared/param_map.svh
`ifndef PARAM_MAP_SVH
`define PARAM_MAP_SVH

// Request codes carried in byte 1
`define CODE_PARAM_READ 8'h81
`define CODE_PARAM_WRITE 8'h86

// Parameter index range
`define PARAM_INDEX_MIN 8'h00
`define PARAM_INDEX_MAX 8'hf1
`define PARAM_COUNT 242

// Filler byte that the requester drives
`define FILLER_BYTE 8'hff

// Frame geometry: byte n sits at bits [8*n-1 -: 8], byte 1 in the low bits
`define FRAME_BYTES 8
`define FRAME_BITS 64
`define BYTE1_LSB 0
`define BYTE2_LSB 8
`define BYTE3_LSB 16
`define BYTE4_LSB 24
`define BYTE5_LSB 32
`define BYTE6_LSB 40

// Reply status byte (byte 5) fields
`define STAT_CODE_BAD_BIT 0
`define STAT_INDEX_BAD_BIT 1
`define STAT_FILLER_BAD_BIT 2
`define STAT_STORED_BIT 3

// Reset value of every stored parameter
`define PARAM_RESET_VALUE 16'h0000

`endif

//--- shared/param_pkg.sv
package param_pkg;

    typedef logic [63:0] frame_t;
    typedef logic [15:0] value_t;
    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_ACCESS = 3'b010,
        DEV_REPLY = 3'b100
    } dev_state_e;

    typedef enum logic [2:0] {
        REQ_IDLE = 3'b001,
        REQ_SEND = 3'b010,
        REQ_WAIT = 3'b100
    } req_state_e;

endpackage

//--- shared/param_link_if.sv
`timescale 1ns/1ns
interface param_link_if;
    logic req_valid;
    logic req_ready;
    param_pkg::frame_t req_frame;
    logic rsp_valid;
    logic rsp_ready;
    param_pkg::frame_t rsp_frame;

    modport device (
        input req_valid,
        input req_frame,
        output req_ready,
        output rsp_valid,
        output rsp_frame,
        input rsp_ready
    );

    modport requester (
        output req_valid,
        output req_frame,
        input req_ready,
        input rsp_valid,
        input rsp_frame,
        output rsp_ready
    );
endinterface

//--- rtl/param_device.sv
`timescale 1ns/1ns
`include "param_map.svh"

module param_device (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic srst, // Synchronous reset, active high
    param_link_if.device link, // Request and reply frames
    input wire logic [7:0] peek_index, // Local parameter read index
    output logic [15:0] peek_value, // Parameter at peek_index, one cycle late
    output logic write_pulse, // One-cycle pulse when a parameter is stored
    output logic [7:0] write_index, // Index of last stored parameter
    output logic [15:0] write_value // Value of last stored parameter
);

    param_pkg::dev_state_e state;
    param_pkg::dev_state_e next_state;

    logic [15:0] param_mem [0:`PARAM_COUNT-1];

    param_pkg::byte_t code;
    param_pkg::byte_t index;
    param_pkg::value_t value;
    logic filler_bad;
    param_pkg::value_t read_value;
    logic stored;
    logic req_ready;
    logic rsp_valid;
    param_pkg::frame_t rsp_frame;

    // Request field decode
    wire accept = link.req_valid && req_ready;
    wire param_pkg::byte_t in_code = link.req_frame[`BYTE1_LSB +: 8];
    wire param_pkg::byte_t in_index = link.req_frame[`BYTE2_LSB +: 8];
    wire param_pkg::value_t in_value = link.req_frame[`BYTE3_LSB +: 16];
    wire in_is_read = in_code == `CODE_PARAM_READ;
    wire value_fill_bad = in_is_read && (in_value != {`FILLER_BYTE, `FILLER_BYTE});
    wire tail_fill_bad = link.req_frame[`BYTE5_LSB +: 32] != {4{`FILLER_BYTE}};

    // Checks on the captured request
    wire code_is_read = code == `CODE_PARAM_READ;
    wire code_is_write = code == `CODE_PARAM_WRITE;
    wire code_bad = !code_is_read && !code_is_write;
    wire index_ok = index <= `PARAM_INDEX_MAX;
    wire do_write = (state == param_pkg::DEV_ACCESS) && code_is_write && index_ok;
    wire do_read = (state == param_pkg::DEV_ACCESS) && code_is_read && index_ok;
    wire peek_ok = peek_index <= `PARAM_INDEX_MAX;
    // Reply leaves only on a completed handshake
    wire reply_taken = rsp_valid && link.rsp_ready;

    // Status byte of the reply
    wire param_pkg::byte_t status = {
        4'h0,
        stored,
        filler_bad,
        !index_ok,
        code_bad
    };

    // Reply frame: echo code, index, value, status, filler
    wire param_pkg::frame_t next_rsp_frame = {
        {3{`FILLER_BYTE}},
        status,
        read_value,
        index,
        code
    };

    always_comb
    begin
        next_state = state;
        unique case (state)
            param_pkg::DEV_IDLE:
            begin
                if (accept)
                    next_state = param_pkg::DEV_ACCESS;
            end
            param_pkg::DEV_ACCESS:
            begin
                next_state = param_pkg::DEV_REPLY;
            end
            param_pkg::DEV_REPLY:
            begin
                // Reply waits as long as needed
                if (reply_taken)
                    next_state = param_pkg::DEV_IDLE;
            end
            default:
            begin
                next_state = param_pkg::DEV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            state <= param_pkg::DEV_IDLE;
        else
            state <= next_state;
    end

    // Capture of one request; only one in flight
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            code <= 8'h00;
            index <= 8'h00;
            value <= 16'h0000;
            filler_bad <= 1'b0;
        end
        else if (accept)
        begin
            code <= in_code;
            index <= in_index;
            value <= in_value;
            filler_bad <= value_fill_bad || tail_fill_bad;
        end
    end

    // Parameter store
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            for (int i = 0; i < `PARAM_COUNT; i++)
                param_mem[i] <= `PARAM_RESET_VALUE;
        end
        else if (do_write)
            param_mem[index] <= value;
    end

    // Read result and store outcome for the reply
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            read_value <= 16'h0000;
            stored <= 1'b0;
        end
        else if (state == param_pkg::DEV_ACCESS)
        begin
            stored <= do_write;
            if (do_read)
                read_value <= param_mem[index];
            else if (do_write)
                read_value <= value;
            else
                read_value <= {`FILLER_BYTE, `FILLER_BYTE};
        end
    end

    // Link handshake and reply frame
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_frame <= {`FRAME_BITS{1'b1}};
        end
        else
        begin
            req_ready <= (next_state == param_pkg::DEV_IDLE) && !accept;
            rsp_valid <= (state == param_pkg::DEV_REPLY) && !reply_taken;
            if (state == param_pkg::DEV_REPLY && !rsp_valid)
                rsp_frame <= next_rsp_frame;
        end
    end

    assign link.req_ready = req_ready;
    assign link.rsp_valid = rsp_valid;
    assign link.rsp_frame = rsp_frame;

    // Local side outputs
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            peek_value <= 16'h0000;
            write_pulse <= 1'b0;
            write_index <= 8'h00;
            write_value <= 16'h0000;
        end
        else
        begin
            peek_value <= peek_ok ? param_mem[peek_index] : 16'h0000;
            write_pulse <= do_write;
            if (do_write)
            begin
                write_index <= index;
                write_value <= value;
            end
        end
    end

endmodule

//--- rtl/param_requester.sv
`timescale 1ns/1ns
`include "param_map.svh"

module param_requester (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic srst, // Synchronous reset, active high
    param_link_if.requester link, // Request and reply frames
    input wire logic start, // Pulse: issue one request
    input wire logic write_en, // 1 write, 0 read
    input wire logic [7:0] index, // Target parameter
    input wire logic [15:0] value, // Value for a write
    output logic busy, // A request is outstanding
    output logic done, // One-cycle pulse, reply taken
    output logic [63:0] reply // Last reply frame
);

    param_pkg::req_state_e state;
    param_pkg::req_state_e next_state;
    logic req_valid;
    param_pkg::frame_t req_frame;

    wire take = start && (state == param_pkg::REQ_IDLE);
    wire param_pkg::byte_t new_code = write_en ? `CODE_PARAM_WRITE : `CODE_PARAM_READ;
    wire param_pkg::value_t new_value = write_en ? value : {`FILLER_BYTE, `FILLER_BYTE};
    wire param_pkg::frame_t new_frame = {{4{`FILLER_BYTE}}, new_value, index, new_code};
    wire sent = link.req_ready && req_valid;

    always_comb
    begin
        next_state = state;
        unique case (state)
            param_pkg::REQ_IDLE:
            begin
                if (take)
                    next_state = param_pkg::REQ_SEND;
            end
            param_pkg::REQ_SEND:
            begin
                if (sent)
                    next_state = param_pkg::REQ_WAIT;
            end
            param_pkg::REQ_WAIT:
            begin
                if (link.rsp_valid)
                    next_state = param_pkg::REQ_IDLE;
            end
            default:
            begin
                next_state = param_pkg::REQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state <= param_pkg::REQ_IDLE;
            req_valid <= 1'b0;
            req_frame <= {`FRAME_BITS{1'b1}};
            busy <= 1'b0;
            done <= 1'b0;
            reply <= 64'h0;
        end
        else
        begin
            state <= next_state;
            req_valid <= next_state == param_pkg::REQ_SEND;
            busy <= next_state != param_pkg::REQ_IDLE;
            done <= (state == param_pkg::REQ_WAIT) && link.rsp_valid;
            if (take)
                req_frame <= new_frame;
            if ((state == param_pkg::REQ_WAIT) && link.rsp_valid)
                reply <= link.rsp_frame;
        end
    end

    assign link.req_valid = req_valid;
    assign link.req_frame = req_frame;
    assign link.rsp_ready = state == param_pkg::REQ_WAIT;

endmodule

//--- verif/param_link_monitor.sv
`timescale 1ns/1ns
module param_link_monitor (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic req_valid, // Request offered
    input wire logic req_ready, // Device ready
    input wire param_pkg::frame_t req_frame, // Request frame
    input wire logic rsp_valid, // Reply present
    input wire logic rsp_ready, // Requester waiting
    input wire param_pkg::frame_t rsp_frame // Reply frame
);
    param_pkg::frame_t last_req;
    wire logic taken = req_valid && req_ready;
    wire logic is_read = last_req[7:0] == 8'h81;
    wire logic is_write = last_req[7:0] == 8'h86;
    wire logic idx_ok = last_req[15:8] <= 8'hf1;
    wire logic filler_ok = last_req[63:32] == 32'hffffffff && (is_write || last_req[31:16] == 16'hffff);

    always_ff @(posedge clk_sys)
        if (srst)
            last_req <= '1;
        else if (taken)
            last_req <= req_frame;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_reply_window: assert property (taken |-> ##[2:4] rsp_valid)
        else $error("reply late");
    a_busy_refuse: assert property (taken |=> !req_ready [*3])
        else $error("second request accepted");
    a_code_echo: assert property (rsp_valid |-> rsp_frame[15:0] == last_req[15:0])
        else $error("code or index not echoed");
    a_write_value: assert property (rsp_valid && is_write && idx_ok |->
        rsp_frame[31:16] == last_req[31:16] && rsp_frame[35])
        else $error("write value wrong");
    a_read_status: assert property (rsp_valid && is_read |-> !rsp_frame[35] && !rsp_frame[32])
        else $error("read status wrong");
    a_bad_index: assert property (rsp_valid && !idx_ok |->
        rsp_frame[33] && !rsp_frame[35] && rsp_frame[31:16] == 16'hffff)
        else $error("bad index handled wrong");
    a_reply_tail: assert property (rsp_valid |-> rsp_frame[63:40] == 24'hffffff)
        else $error("reply tail wrong");
    a_reply_drop: assert property (rsp_valid && rsp_ready |=> !rsp_valid)
        else $error("reply not dropped");
    a_filler_clean: assert property (rsp_valid && filler_ok |-> !rsp_frame[34])
        else $error("filler flagged wrongly");
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 0;
    logic srst = 1;
    logic start = 0;
    logic write_en = 0;
    logic [7:0] index = 8'h00;
    logic [15:0] value = 16'h0000;
    logic [7:0] peek_index = 8'h00;
    logic [15:0] peek_value, write_value;
    logic [7:0] write_index;
    logic write_pulse, busy, done;
    logic [63:0] reply;
    logic [15:0] mem [256];
    int err_count = 0;
    int samples_checked = 0;
    int pulse_count = 0;

    param_link_if link ();
    param_device param_device_inst (.clk_sys(clk_sys), .srst(srst), .link(link), .peek_index(peek_index),
        .peek_value(peek_value), .write_pulse(write_pulse), .write_index(write_index),
        .write_value(write_value));
    param_requester param_requester_inst (.clk_sys(clk_sys), .srst(srst), .link(link), .start(start),
        .write_en(write_en), .index(index), .value(value), .busy(busy), .done(done), .reply(reply));
    param_link_monitor param_link_monitor_inst (.clk_sys(clk_sys), .srst(srst), .req_valid(link.req_valid),
        .req_ready(link.req_ready), .req_frame(link.req_frame), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_frame(link.rsp_frame));

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys)
    begin
        if (write_pulse === 1'b1)
            pulse_count++;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [63:0] exp_reply(input logic we, input logic [7:0] idx, input logic [15:0] val);
        logic ok;
        logic [15:0] v;
        ok = idx <= 8'hf1;
        v = !ok ? 16'hffff : (we ? val : mem[idx]);
        return {24'hffffff, 4'h0, we && ok, 1'b0, !ok, 1'b0, v, idx, we ? 8'h86 : 8'h81};
    endfunction

    task automatic op(input logic we, input logic [7:0] idx, input logic [15:0] val);
        logic [63:0] exp;
        int n;
        int pulses;
        exp = exp_reply(we, idx, val);
        pulses = pulse_count;
        @(negedge clk_sys);
        start = 1;
        write_en = we;
        index = idx;
        value = val;
        peek_index = idx;
        @(negedge clk_sys);
        start = 0;
        check({63'h0, busy}, 64'h1);
        for (n = 0; n < 50 && !done; n++)
            @(negedge clk_sys);
        check({63'h0, done}, 64'h1);
        check({63'h0, busy}, 64'h0);
        check(pulse_count - pulses, (we && idx <= 8'hf1) ? 1 : 0);
        check(reply, exp);
        if (we && idx <= 8'hf1)
        begin
            mem[idx] = val;
            check({write_index, write_value}, {idx, val});
        end
        @(negedge clk_sys);
        check(peek_value, idx <= 8'hf1 ? mem[idx] : 16'h0000);
    endtask

    task automatic end_of_test;
        $display("Counts: %0d checked, %0d mismatches", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #300000;
        err_count++;
        end_of_test;
    end

    initial
    begin
        foreach (mem[i])
            mem[i] = 16'h0000;
        void'($urandom(99094));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 0;
        check(peek_value, 16'h0000);
        $display("test reset done");
        op(0, 8'h00, 16'h0000);
        op(1, 8'hf1, 16'hffff);
        op(0, 8'hf1, 16'h0000);
        op(1, 8'hf2, 16'h1234);
        op(0, 8'hff, 16'h0000);
        op(1, 8'h00, 16'h00ff);
        op(0, 8'h00, 16'h0000);
        $display("test corners done");
        repeat (150)
            op(1'($urandom), 8'($urandom), 16'($urandom));
        $display("test random done");
        end_of_test;
    end
endmodule
